// ### core/t16wc_regs.svh
// register indices, field positions, codes, prescale masks and counter constants of the timer block
`ifndef T16WC_REGS_SVH
`define T16WC_REGS_SVH

`define T16WC_IDX_RUN_CTL 6'h00
`define T16WC_IDX_WAVE_CFG 6'h01
`define T16WC_IDX_LVL_PRE 6'h02
`define T16WC_IDX_SPLIT_SEL 6'h03
`define T16WC_IDX_CMD_CLR 6'h04
`define T16WC_IDX_CMD_SET 6'h05
`define T16WC_IDX_BUF_CLR 6'h06
`define T16WC_IDX_BUF_SET 6'h07
`define T16WC_IDX_EVT_CTL 6'h09
`define T16WC_IDX_IRQ_EN 6'h0a
`define T16WC_IDX_IRQ_FLG 6'h0b
`define T16WC_IDX_HALT_CTL 6'h0e
`define T16WC_IDX_STAGE 6'h0f
`define T16WC_IDX_COUNT 6'h20
`define T16WC_IDX_TOP 6'h26
`define T16WC_IDX_MATCH0 6'h28
`define T16WC_IDX_MATCH1 6'h2a
`define T16WC_IDX_MATCH2 6'h2c
`define T16WC_IDX_TOPBUF 6'h36
`define T16WC_IDX_MBUF0 6'h38
`define T16WC_IDX_MBUF1 6'h3a
`define T16WC_IDX_MBUF2 6'h3c

`define T16WC_RUN_BIT 0
`define T16WC_PSEL_MSB 3
`define T16WC_PSEL_LSB 1
`define T16WC_KIND_MSB 2
`define T16WC_KIND_LSB 0
`define T16WC_ATL_BIT 3
`define T16WC_OVR_MSB 6
`define T16WC_OVR_LSB 4
`define T16WC_CMD_MSB 3
`define T16WC_CMD_LSB 2
`define T16WC_LOCK_BIT 1
`define T16WC_DIR_BIT 0
`define T16WC_TBV_BIT 0
`define T16WC_MBV_MSB 3
`define T16WC_MBV_LSB 1
`define T16WC_WRAP_BIT 0
`define T16WC_HIT_MSB 6
`define T16WC_HIT_LSB 4

`define T16WC_KIND_NORMAL 3'h0
`define T16WC_KIND_FREQ 3'h1
`define T16WC_KIND_ONE_RAMP 3'h3
`define T16WC_KIND_TWO_TOP 3'h5
`define T16WC_KIND_TWO_BOTH 3'h6
`define T16WC_KIND_TWO_LOW 3'h7

`define T16WC_CMD_NONE 2'h0
`define T16WC_CMD_UPDATE 2'h1
`define T16WC_CMD_RESTART 2'h2
`define T16WC_CMD_RESET 2'h3

`define T16WC_MASK_DIV1 10'h000
`define T16WC_MASK_DIV2 10'h001
`define T16WC_MASK_DIV4 10'h003
`define T16WC_MASK_DIV8 10'h007
`define T16WC_MASK_DIV16 10'h00f
`define T16WC_MASK_DIV64 10'h03f
`define T16WC_MASK_DIV256 10'h0ff
`define T16WC_MASK_DIV1024 10'h3ff

`define T16WC_CNT_ZERO 16'h0000
`define T16WC_CNT_ONE 16'h0001

`endif

// ### core/t16wc_pkg.sv
// types shared by the timer block
package t16wc_pkg;
  typedef enum logic {T16WC_UP, T16WC_DOWN} t16wc_dir_e;

  typedef struct packed {
    logic [9:0] cnt;
  } t16wc_presc_s;

  typedef struct packed {
    logic [3:0] run_ctl;
    logic [6:0] wave_cfg;
    logic [2:0] lvl_pre;
    logic split;
    logic lock;
    t16wc_dir_e dir;
    logic [3:0] bv;
    logic [2:0] evt;
    logic [3:0] irq_en;
    logic [3:0] irq_flg;
    logic halt;
    logic [7:0] stage;
    logic [15:0] cnt;
    logic [15:0] top;
    logic [15:0] topbuf;
    logic [2:0][15:0] match;
    logic [2:0][15:0] mbuf;
    logic [2:0] wg;
    logic [2:0] pin;
    logic [31:0] rdata;
  } t16wc_state_s;
endpackage : t16wc_pkg

// ### core/t16wc_prescale.sv
// prescaler that turns the peripheral clock into timer ticks
`timescale 1ns/100ps
`include "t16wc_regs.svh"

module t16wc_prescale (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [2:0] select,
  output logic tick
);
  t16wc_pkg::t16wc_presc_s s_q;
  t16wc_pkg::t16wc_presc_s s_d;
  logic [9:0] mask;

  function automatic logic [9:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h0: div_mask = `T16WC_MASK_DIV1;
      3'h1: div_mask = `T16WC_MASK_DIV2;
      3'h2: div_mask = `T16WC_MASK_DIV4;
      3'h3: div_mask = `T16WC_MASK_DIV8;
      3'h4: div_mask = `T16WC_MASK_DIV16;
      3'h5: div_mask = `T16WC_MASK_DIV64;
      3'h6: div_mask = `T16WC_MASK_DIV256;
      default: div_mask = `T16WC_MASK_DIV1024;
    endcase
  endfunction : div_mask

  assign mask = div_mask(select);
  assign tick = run && ((s_q.cnt & mask) == mask);

  always_comb
  begin
    s_d = s_q;
    s_d.cnt = run ? (s_q.cnt + 10'h001) : 10'h000;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule : t16wc_prescale

// ### core/t16wc_timer.sv
// 16-bit timer control, buffering, waveform select and apb register file
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "t16wc_regs.svh"

// Operation
// - tick is the clock divided by 1,2,4,8,16,64,256 or 1024 per select
// - run bit 0 disables or enables the timer
// - in the waveform kinds a set override bit makes channel waveform replace port output value
// - auto lock holds lock until all enabled channel buffers are written
// - lock then stays clear until update copies buffers and sets lock again
// - with auto lock off hardware never changes the lock bit
// - kind codes: normal, frequency, one-ramp pwm, three two-ramp pwm kinds
// - top is the top register except in frequency kind, where match 0
// - per-kind points for loading buffers and raising the wrap flag
// - normal kind drives no waveform on any pin
// - generator result reaches a pin only with its override bit set
// - lock set blocks copying at update points but not on the update command; lock clear copies at the next update point
// - buffer write sets its written flag; update clears it
// - while stopped, level presets drive the generator outputs directly
// - command codes none, update, restart, reset; reset only when stopped
module t16wc_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] port_out,
  output logic [2:0] waveform_pin
);
  t16wc_pkg::t16wc_state_s s_q;
  t16wc_pkg::t16wc_state_s s_d;
  logic tick;
  logic [5:0] idx;
  logic wr;
  logic mapped;
  logic [2:0] kind;
  logic run;
  logic atl;
  logic [2:0] ovr;
  logic dual;
  logic wave_kind;
  logic [15:0] top_src;
  logic at_top;
  logic at_bot;
  logic upd_evt;
  logic wrap_evt;
  logic [1:0] cmd;
  logic do_copy;

  function automatic logic is_mapped(input logic [5:0] i);
    if (i == `T16WC_IDX_RUN_CTL || i == `T16WC_IDX_WAVE_CFG || i == `T16WC_IDX_LVL_PRE)
      is_mapped = 1'b1;
    else if (i == `T16WC_IDX_SPLIT_SEL || i == `T16WC_IDX_CMD_CLR || i == `T16WC_IDX_CMD_SET)
      is_mapped = 1'b1;
    else if (i == `T16WC_IDX_BUF_CLR || i == `T16WC_IDX_BUF_SET || i == `T16WC_IDX_EVT_CTL)
      is_mapped = 1'b1;
    else if (i == `T16WC_IDX_IRQ_EN || i == `T16WC_IDX_IRQ_FLG || i == `T16WC_IDX_HALT_CTL)
      is_mapped = 1'b1;
    else if (i == `T16WC_IDX_STAGE || i == `T16WC_IDX_COUNT || i == `T16WC_IDX_TOP)
      is_mapped = 1'b1;
    else if (i == `T16WC_IDX_MATCH0 || i == `T16WC_IDX_MATCH1 || i == `T16WC_IDX_MATCH2)
      is_mapped = 1'b1;
    else if (i == `T16WC_IDX_TOPBUF || i == `T16WC_IDX_MBUF0 || i == `T16WC_IDX_MBUF1)
      is_mapped = 1'b1;
    else
      is_mapped = (i == `T16WC_IDX_MBUF2);
  endfunction : is_mapped

  function automatic logic [31:0] rd_word(input t16wc_pkg::t16wc_state_s s,
                                          input logic [5:0] i);
    // command field always reads zero
    if (i == `T16WC_IDX_RUN_CTL)
      rd_word = {28'h0000000, s.run_ctl};
    else if (i == `T16WC_IDX_WAVE_CFG)
      rd_word = {25'h0000000, s.wave_cfg};
    else if (i == `T16WC_IDX_LVL_PRE)
      rd_word = {29'h00000000, s.lvl_pre};
    else if (i == `T16WC_IDX_SPLIT_SEL)
      rd_word = {31'h00000000, s.split};
    else if (i == `T16WC_IDX_CMD_CLR || i == `T16WC_IDX_CMD_SET)
      rd_word = {30'h00000000, s.lock, s.dir};
    else if (i == `T16WC_IDX_BUF_CLR || i == `T16WC_IDX_BUF_SET)
      rd_word = {28'h0000000, s.bv};
    else if (i == `T16WC_IDX_EVT_CTL)
      rd_word = {29'h00000000, s.evt};
    else if (i == `T16WC_IDX_IRQ_EN)
      rd_word = {25'h0000000, s.irq_en[3:1], 3'h0, s.irq_en[0]};
    else if (i == `T16WC_IDX_IRQ_FLG)
      rd_word = {25'h0000000, s.irq_flg[3:1], 3'h0, s.irq_flg[0]};
    else if (i == `T16WC_IDX_HALT_CTL)
      rd_word = {31'h00000000, s.halt};
    else if (i == `T16WC_IDX_STAGE)
      rd_word = {24'h000000, s.stage};
    else if (i == `T16WC_IDX_COUNT)
      rd_word = {16'h0000, s.cnt};
    else if (i == `T16WC_IDX_TOP)
      rd_word = {16'h0000, s.top};
    else if (i == `T16WC_IDX_MATCH0)
      rd_word = {16'h0000, s.match[0]};
    else if (i == `T16WC_IDX_MATCH1)
      rd_word = {16'h0000, s.match[1]};
    else if (i == `T16WC_IDX_MATCH2)
      rd_word = {16'h0000, s.match[2]};
    else if (i == `T16WC_IDX_TOPBUF)
      rd_word = {16'h0000, s.topbuf};
    else if (i == `T16WC_IDX_MBUF0)
      rd_word = {16'h0000, s.mbuf[0]};
    else if (i == `T16WC_IDX_MBUF1)
      rd_word = {16'h0000, s.mbuf[1]};
    else if (i == `T16WC_IDX_MBUF2)
      rd_word = {16'h0000, s.mbuf[2]};
    else
      rd_word = 32'h00000000;
  endfunction : rd_word

  t16wc_prescale u_prescale (
    .clk(clk),
    .reset(reset),
    .run(run),
    .select(s_q.run_ctl[`T16WC_PSEL_MSB:`T16WC_PSEL_LSB]),
    .tick(tick)
  );

  assign idx = paddr[7:2];
  assign mapped = is_mapped(idx) && (paddr[1:0] == 2'h0);
  assign wr = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_q.rdata;
  assign waveform_pin = s_q.pin;

  assign run = s_q.run_ctl[`T16WC_RUN_BIT];
  assign kind = s_q.wave_cfg[`T16WC_KIND_MSB:`T16WC_KIND_LSB];
  assign atl = s_q.wave_cfg[`T16WC_ATL_BIT];
  assign ovr = s_q.wave_cfg[`T16WC_OVR_MSB:`T16WC_OVR_LSB];
  assign dual = (kind == `T16WC_KIND_TWO_TOP) || (kind == `T16WC_KIND_TWO_BOTH) ||
                (kind == `T16WC_KIND_TWO_LOW);
  assign wave_kind = dual || (kind == `T16WC_KIND_FREQ) || (kind == `T16WC_KIND_ONE_RAMP);
  assign top_src = (kind == `T16WC_KIND_FREQ) ? s_q.match[0] : s_q.top;
  assign at_top = run && tick && (s_q.cnt == top_src) && (s_q.dir == t16wc_pkg::T16WC_UP);
  assign at_bot = run && tick && dual && (s_q.cnt == `T16WC_CNT_ZERO) &&
                  (s_q.dir == t16wc_pkg::T16WC_DOWN);
  // load and wrap points per kind
  assign upd_evt = dual ? at_bot : at_top;
  assign wrap_evt = (kind == `T16WC_KIND_TWO_BOTH) ? (at_top || at_bot) :
                    (kind == `T16WC_KIND_TWO_LOW) ? at_bot : at_top;
  // command only from the set register
  assign cmd = (wr && idx == `T16WC_IDX_CMD_SET) ?
               pwdata[`T16WC_CMD_MSB:`T16WC_CMD_LSB] : `T16WC_CMD_NONE;
  // lock blocks copying, forced update ignores it
  assign do_copy = (upd_evt && !s_q.lock) || (cmd == `T16WC_CMD_UPDATE);

  always_comb
  begin
    s_d = s_q;
    if (run && tick)
    begin
      if (dual)
      begin
        if (at_top)
        begin
          s_d.dir = t16wc_pkg::T16WC_DOWN;
          s_d.cnt = s_q.cnt - `T16WC_CNT_ONE;
        end
        else if (at_bot)
        begin
          s_d.dir = t16wc_pkg::T16WC_UP;
          s_d.cnt = s_q.cnt + `T16WC_CNT_ONE;
        end
        else if (s_q.dir == t16wc_pkg::T16WC_DOWN)
          s_d.cnt = s_q.cnt - `T16WC_CNT_ONE;
        else
          s_d.cnt = s_q.cnt + `T16WC_CNT_ONE;
      end
      else
        s_d.cnt = at_top ? `T16WC_CNT_ZERO : (s_q.cnt + `T16WC_CNT_ONE);
    end
    // generator outputs
    for (int i = 0; i < 3; i++)
    begin
      if (!run)
        s_d.wg[i] = s_q.lvl_pre[i];
      else if (tick && s_q.cnt == s_q.match[i])
      begin
        s_d.irq_flg[i + 1] = 1'b1;
        if (kind == `T16WC_KIND_FREQ)
          s_d.wg[i] = !s_q.wg[i];
        else if (kind == `T16WC_KIND_ONE_RAMP)
          s_d.wg[i] = 1'b0;
        else if (dual)
          s_d.wg[i] = (s_q.dir == t16wc_pkg::T16WC_DOWN);
      end
      else if (kind == `T16WC_KIND_ONE_RAMP && at_top)
        s_d.wg[i] = 1'b1;
    end
    // auto lock clears once enabled buffers are written
    if (atl && s_q.lock && ((s_q.bv[`T16WC_MBV_MSB:`T16WC_MBV_LSB] & ovr) == ovr))
      s_d.lock = 1'b0;
    if (do_copy)
    begin
      if (s_q.bv[`T16WC_TBV_BIT])
        s_d.top = s_q.topbuf;
      for (int i = 0; i < 3; i++)
      begin
        if (s_q.bv[i + 1])
          s_d.match[i] = s_q.mbuf[i];
      end
      s_d.bv = 4'h0;
      // lock is set again at the update, never without auto lock
      if (atl)
        s_d.lock = 1'b1;
    end
    // software writes
    if (wr)
    begin
      if (idx == `T16WC_IDX_RUN_CTL)
        s_d.run_ctl = pwdata[3:0];
      else if (idx == `T16WC_IDX_WAVE_CFG)
      begin
        s_d.wave_cfg = pwdata[6:0];
        // turning auto lock on locks until the enabled buffers are written
        if (pwdata[`T16WC_ATL_BIT] && !atl)
          s_d.lock = 1'b1;
      end
      else if (idx == `T16WC_IDX_LVL_PRE)
        s_d.lvl_pre = pwdata[2:0];
      else if (idx == `T16WC_IDX_SPLIT_SEL)
        s_d.split = pwdata[0];
      else if (idx == `T16WC_IDX_CMD_CLR)
      begin
        if (pwdata[`T16WC_LOCK_BIT])
          s_d.lock = 1'b0;
        if (pwdata[`T16WC_DIR_BIT])
          s_d.dir = t16wc_pkg::T16WC_UP;
      end
      else if (idx == `T16WC_IDX_CMD_SET)
      begin
        if (pwdata[`T16WC_LOCK_BIT])
          s_d.lock = 1'b1;
        if (pwdata[`T16WC_DIR_BIT])
          s_d.dir = t16wc_pkg::T16WC_DOWN;
      end
      else if (idx == `T16WC_IDX_BUF_CLR)
        s_d.bv = s_d.bv & ~pwdata[3:0];
      else if (idx == `T16WC_IDX_BUF_SET)
        s_d.bv = s_d.bv | pwdata[3:0];
      else if (idx == `T16WC_IDX_EVT_CTL)
        s_d.evt = pwdata[2:0];
      else if (idx == `T16WC_IDX_IRQ_EN)
        s_d.irq_en = {pwdata[`T16WC_HIT_MSB:`T16WC_HIT_LSB], pwdata[`T16WC_WRAP_BIT]};
      else if (idx == `T16WC_IDX_IRQ_FLG)
        // write one clears, but a hit in this cycle stays set
        s_d.irq_flg = s_q.irq_flg & ~{pwdata[`T16WC_HIT_MSB:`T16WC_HIT_LSB],
                                      pwdata[`T16WC_WRAP_BIT]};
      else if (idx == `T16WC_IDX_HALT_CTL)
        s_d.halt = pwdata[0];
      else if (idx == `T16WC_IDX_STAGE)
        s_d.stage = pwdata[7:0];
      else if (idx == `T16WC_IDX_COUNT)
        s_d.cnt = pwdata[15:0];
      else if (idx == `T16WC_IDX_TOP)
        s_d.top = pwdata[15:0];
      else if (idx == `T16WC_IDX_MATCH0)
        s_d.match[0] = pwdata[15:0];
      else if (idx == `T16WC_IDX_MATCH1)
        s_d.match[1] = pwdata[15:0];
      else if (idx == `T16WC_IDX_MATCH2)
        s_d.match[2] = pwdata[15:0];
      else if (idx == `T16WC_IDX_TOPBUF)
      begin
        s_d.topbuf = pwdata[15:0];
        s_d.bv[`T16WC_TBV_BIT] = 1'b1;
      end
      else if (idx == `T16WC_IDX_MBUF0 || idx == `T16WC_IDX_MBUF1 || idx == `T16WC_IDX_MBUF2)
      begin
        s_d.mbuf[idx[2:1]] = pwdata[15:0];
        s_d.bv[idx[2:1] + 2'h1] = 1'b1;
      end
    end
    // hits in the cycle of a clear win
    if (wrap_evt)
      s_d.irq_flg[`T16WC_WRAP_BIT] = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      if (run && tick && s_q.cnt == s_q.match[i])
        s_d.irq_flg[i + 1] = 1'b1;
    end
    if (cmd == `T16WC_CMD_RESTART)
    begin
      s_d.cnt = `T16WC_CNT_ZERO;
      s_d.dir = t16wc_pkg::T16WC_UP;
      s_d.wg = 3'h0;
    end
    else if (cmd == `T16WC_CMD_RESET && !run)
      s_d = '0;
    // override selects generator or port value
    for (int i = 0; i < 3; i++)
      s_d.pin[i] = (wave_kind && ovr[i]) ? s_q.wg[i] : port_out[i];
    if (psel && !penable && !pwrite)
      s_d.rdata = rd_word(s_q, idx);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  AST_DIV1_EVERY_CYCLE: assert property (@(posedge clk) disable iff (reset)
    (run && s_q.run_ctl[`T16WC_PSEL_MSB:`T16WC_PSEL_LSB] == 3'h0) |-> tick)
    else $error("undivided prescale missed a tick");
  AST_HOLD_STOPPED: assert property (@(posedge clk) disable iff (reset)
    (!run && !wr) |=> $stable(s_q.cnt))
    else $error("counter moved while stopped");
  AST_PORT_KEPT: assert property (@(posedge clk) disable iff (reset)
    (!reset && !ovr[0]) |=> (s_q.pin[0] == $past(port_out[0])))
    else $error("pin left port value without override");
  AST_NORMAL_NO_WAVE: assert property (@(posedge clk) disable iff (reset)
    (!reset && kind == `T16WC_KIND_NORMAL) |=> (s_q.pin == $past(port_out)))
    else $error("normal kind drove a waveform");
  AST_WAVE_ON_PIN: assert property (@(posedge clk) disable iff (reset)
    (wave_kind && ovr[1]) |=> (s_q.pin[1] == $past(s_q.wg[1])))
    else $error("generator result missing on pin");
  AST_AUTO_UNLOCK: assert property (@(posedge clk) disable iff (reset)
    (atl && s_q.lock && !wr && !do_copy &&
     ((s_q.bv[`T16WC_MBV_MSB:`T16WC_MBV_LSB] & ovr) == ovr)) |=> !s_q.lock)
    else $error("auto lock not released");
  AST_RELOCK_AT_UPDATE: assert property (@(posedge clk) disable iff (reset)
    (atl && !s_q.lock && upd_evt && !wr) |=> s_q.lock)
    else $error("lock not set at update");
  AST_NO_HW_LOCK: assert property (@(posedge clk) disable iff (reset)
    (!atl && !wr) |=> $stable(s_q.lock))
    else $error("hardware changed lock");
  AST_LOCKED_NO_COPY: assert property (@(posedge clk) disable iff (reset)
    (s_q.lock && upd_evt && !wr) |=> ($stable(s_q.match) && $stable(s_q.top)))
    else $error("copy happened under lock");
  AST_FLAG_ON_WRITE: assert property (@(posedge clk) disable iff (reset)
    (wr && idx == `T16WC_IDX_MBUF0) |=> s_q.bv[1])
    else $error("buffer flag not set");
  AST_PRESET_STOPPED: assert property (@(posedge clk) disable iff (reset)
    (!run && !wr) |=> (s_q.wg == $past(s_q.lvl_pre)))
    else $error("preset not applied");
  AST_CMD_READS_ZERO: assert property (@(posedge clk) disable iff (reset)
    (psel && penable && !pwrite && idx == `T16WC_IDX_CMD_SET) |-> (prdata[3:2] == 2'h0))
    else $error("command field read nonzero");
  AST_FREQ_TOP: assert property (@(posedge clk) disable iff (reset)
    (kind == `T16WC_KIND_FREQ && at_top && !wr) |=> (s_q.cnt == `T16WC_CNT_ZERO))
    else $error("frequency kind did not wrap at match 0");
  AST_WRAP_FLAG: assert property (@(posedge clk) disable iff (reset)
    (kind == `T16WC_KIND_TWO_LOW && at_bot) |=> s_q.irq_flg[`T16WC_WRAP_BIT])
    else $error("wrap flag not raised at bottom");
endmodule : t16wc_timer

// ### sim/test_timer16_waveform_control.sv
// self-checking bench for the 16-bit timer control block over apb
`timescale 1ns/100ps
`include "t16wc_regs.svh"

module test_timer16_waveform_control;
  logic clk;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] port_out;
  logic [2:0] waveform_pin;
  logic [31:0] q;
  logic e;
  logic [2:0] exp_pin;
  int errors;
  int n_compared;
  int cycles;
  int dv[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

  t16wc_timer uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_out(port_out), .waveform_pin(waveform_pin));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // cuts a hung run short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errors++;
      give_verdict();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_compared++;
    if ($isunknown(got) || !(got >= lo && got <= hi))
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : cmp_rng

  // one apb transfer; waits for pready without assuming a latency
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] rq, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rq = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] rq;
    logic err;
    apb(1'b1, idx, d, rq, err);
  endtask : wr

  task automatic rd(input logic [5:0] idx, output logic [31:0] rq);
    logic err;
    apb(1'b0, idx, 32'h0, rq, err);
  endtask : rd

  task automatic chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] rq;
    rd(idx, rq);
    cmp(rq, exp);
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_out = 3'h2;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    chk(`T16WC_IDX_RUN_CTL, 32'h0);
    chk(`T16WC_IDX_WAVE_CFG, 32'h0);
    chk(`T16WC_IDX_LVL_PRE, 32'h0);
    chk(`T16WC_IDX_CMD_SET, 32'h0);
    chk(`T16WC_IDX_BUF_SET, 32'h0);
    // unmapped index is refused
    apb(1'b0, 6'h08, 32'h0, q, e);
    cmp({31'h0, e}, 32'h1);
    cmp(q, 32'h0);
    // every prescale code, twenty ticks each
    wr(`T16WC_IDX_TOP, 32'hffff);
    for (int s = 0; s < 8; s++)
    begin
      wr(`T16WC_IDX_COUNT, 32'h0);
      wr(`T16WC_IDX_RUN_CTL, {28'h0, s[2:0], 1'b1});
      repeat (20 * dv[s]) @(posedge clk);
      wr(`T16WC_IDX_RUN_CTL, {28'h0, s[2:0], 1'b0});
      rd(`T16WC_IDX_COUNT, q);
      cmp_rng(q, 32'd19, 32'd23);
      repeat (5) @(posedge clk);
      chk(`T16WC_IDX_COUNT, q);
    end
    // manual lock and forced update
    wr(`T16WC_IDX_TOP, 32'h000f);
    wr(`T16WC_IDX_COUNT, 32'h0);
    wr(`T16WC_IDX_CMD_SET, 32'h2);
    wr(`T16WC_IDX_MBUF1, 32'h1234);
    chk(`T16WC_IDX_BUF_SET, 32'h4);
    wr(`T16WC_IDX_CMD_SET, 32'h4);
    chk(`T16WC_IDX_MATCH1, 32'h1234);
    chk(`T16WC_IDX_BUF_SET, 32'h0);
    chk(`T16WC_IDX_CMD_CLR, 32'h2);
    // locked updates copy nothing, unlocked ones copy at the next update
    wr(`T16WC_IDX_MBUF0, 32'h00aa);
    wr(`T16WC_IDX_RUN_CTL, 32'h1);
    repeat (40) @(posedge clk);
    chk(`T16WC_IDX_MATCH0, 32'h0);
    chk(`T16WC_IDX_CMD_SET, 32'h2);
    wr(`T16WC_IDX_CMD_CLR, 32'h2);
    repeat (40) @(posedge clk);
    chk(`T16WC_IDX_MATCH0, 32'h00aa);
    chk(`T16WC_IDX_BUF_SET, 32'h0);
    chk(`T16WC_IDX_CMD_SET, 32'h0);
    wr(`T16WC_IDX_RUN_CTL, 32'h0);
    rd(`T16WC_IDX_IRQ_FLG, q);
    cmp({31'h0, q[0]}, 32'h1);
    wr(`T16WC_IDX_IRQ_FLG, 32'h1);
    rd(`T16WC_IDX_IRQ_FLG, q);
    cmp({31'h0, q[0]}, 32'h0);
    // automatic lock with channels 0 and 1 enabled
    wr(`T16WC_IDX_WAVE_CFG, 32'h38);
    chk(`T16WC_IDX_CMD_SET, 32'h2);
    wr(`T16WC_IDX_MBUF0, 32'h0005);
    chk(`T16WC_IDX_CMD_SET, 32'h2);
    wr(`T16WC_IDX_MBUF1, 32'h0006);
    chk(`T16WC_IDX_CMD_SET, 32'h0);
    wr(`T16WC_IDX_RUN_CTL, 32'h1);
    repeat (40) @(posedge clk);
    wr(`T16WC_IDX_RUN_CTL, 32'h0);
    chk(`T16WC_IDX_MATCH0, 32'h0005);
    chk(`T16WC_IDX_MATCH1, 32'h0006);
    chk(`T16WC_IDX_CMD_SET, 32'h2);
    // pin source for every kind code with all overrides set, timer stopped
    wr(`T16WC_IDX_LVL_PRE, 32'h5);
    for (int k = 0; k < 8; k++)
    begin
      wr(`T16WC_IDX_WAVE_CFG, {25'h0, 3'h7, 1'b0, k[2:0]});
      repeat (3) @(posedge clk);
      exp_pin = (k == 0 || k == 2 || k == 4) ? port_out : 3'h5;
      cmp({29'h0, waveform_pin}, {29'h0, exp_pin});
    end
    // override on channel 0 only
    wr(`T16WC_IDX_WAVE_CFG, 32'h13);
    repeat (3) @(posedge clk);
    cmp({29'h0, waveform_pin}, 32'h3);
    port_out <= 3'h4;
    wr(`T16WC_IDX_LVL_PRE, 32'h2);
    repeat (3) @(posedge clk);
    cmp({29'h0, waveform_pin}, 32'h4);
    // frequency kind wraps at match 0, not at the top register
    wr(`T16WC_IDX_TOP, 32'h00ff);
    wr(`T16WC_IDX_MATCH0, 32'h0003);
    wr(`T16WC_IDX_COUNT, 32'h0);
    wr(`T16WC_IDX_WAVE_CFG, 32'h1);
    wr(`T16WC_IDX_RUN_CTL, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      repeat (7) @(posedge clk);
      rd(`T16WC_IDX_COUNT, q);
      cmp_rng(q, 32'h0, 32'h3);
    end
    // two-ramp kinds from a restart: 23 ticks turn at top 0x10 and end at 9 going down
    wr(`T16WC_IDX_RUN_CTL, 32'h0);
    wr(`T16WC_IDX_TOP, 32'h0010);
    for (int k = 5; k < 8; k++)
    begin
      wr(`T16WC_IDX_CMD_SET, 32'h8);
      wr(`T16WC_IDX_IRQ_FLG, 32'h71);
      wr(`T16WC_IDX_WAVE_CFG, {29'h0, k[2:0]});
      wr(`T16WC_IDX_RUN_CTL, 32'h1);
      repeat (20) @(posedge clk);
      wr(`T16WC_IDX_RUN_CTL, 32'h0);
      chk(`T16WC_IDX_COUNT, 32'h9);
      rd(`T16WC_IDX_IRQ_FLG, q);
      cmp({31'h0, q[0]}, {31'h0, k != 7});
    end
    // low-wrap kind passes bottom after ten more ticks, then climbs to 0xe
    wr(`T16WC_IDX_RUN_CTL, 32'h1);
    repeat (20) @(posedge clk);
    wr(`T16WC_IDX_RUN_CTL, 32'h0);
    chk(`T16WC_IDX_COUNT, 32'he);
    rd(`T16WC_IDX_IRQ_FLG, q);
    cmp({31'h0, q[0]}, 32'h1);
    // restart, then hard reset ignored while running and obeyed when stopped
    wr(`T16WC_IDX_RUN_CTL, 32'h0);
    wr(`T16WC_IDX_CMD_SET, 32'h8);
    chk(`T16WC_IDX_COUNT, 32'h0);
    wr(`T16WC_IDX_RUN_CTL, 32'h1);
    wr(`T16WC_IDX_CMD_SET, 32'hc);
    chk(`T16WC_IDX_TOP, 32'h0010);
    wr(`T16WC_IDX_RUN_CTL, 32'h0);
    wr(`T16WC_IDX_CMD_SET, 32'hc);
    chk(`T16WC_IDX_TOP, 32'h0);
    chk(`T16WC_IDX_MATCH1, 32'h0);
    give_verdict();
  end
endmodule : test_timer16_waveform_control
